// file: rtl/rtmc_pkg.sv
package rtmc_pkg;

    // mode controller states
    typedef enum logic [4:0]
    {
        RTMC_OFF     = 5'b00001,
        RTMC_STANDBY = 5'b00010,
        RTMC_SWITCH  = 5'b00100,
        RTMC_RX      = 5'b01000,
        RTMC_TX      = 5'b10000
    } rtmc_state_t;

    localparam int unsigned LEVEL_STEPS  = 58;
    localparam int unsigned LEVEL_W      = 6;
    localparam logic [5:0]  LEVEL_MAX    = 6'h39;  // 57
    localparam logic [5:0]  LEVEL_MIN    = 6'h00;
    localparam logic [5:0]  LEVEL_RST    = 6'h39;
    // time the radio needs to retune between transmit and receive
    localparam int unsigned SWITCH_NS    = 1000;
    localparam int unsigned CLK_NS       = 100;
    localparam int unsigned SWITCH_CYC   = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  SWITCH_LOAD  = 8'(SWITCH_CYC);
    // data rate limits of the transparent path
    localparam int unsigned RATE_MIN_BPS = 1000;
    localparam int unsigned RATE_MAX_BPS = 300000;

endpackage : rtmc_pkg

// file: rtl/rtmc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - select high: transmit mode, radio follows the transmit data level directly
// - transmit path is a bare level copy, any waveform from 1 to 300 kbps
// - select low: receive mode, demodulated bits drive the receive data output
// - receive output is never squelched, noise passes straight through
// - select change leaves one mode, enters the other, busy high while switching
// - switching touches no other setting; baud band and channel keep their values
// - busy flag high when busy, low when able to transmit or receive
// - power-down low switches all modes off; only baud band and channel still follow their inputs while low
// - standby high or floating means low-power standby; low means fully active
// - in standby all modes stop and busy flag is held high
// - while powered down the busy flag reads low
// - output level input sampled once at power-up, fixed for the session
// - power level is a digital index of 58 steps, about 0.5 dB each
// - strap high or open selects level 57, strap grounded selects level 0
module rtmc_mode_ctrl
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        powerDownN,    // low switches the module off
    input  wire logic        standbyReq,    // high (pulled up) requests standby
    input  wire logic        txSelect,      // high transmit, low receive
    input  wire logic        txData,        // raw transmit level from host
    input  wire logic        demodBit,      // demodulator output
    input  wire logic [5:0]  output_level_strap, // digitised level input
    input  wire logic [1:0]  baudBandIn,
    input  wire logic [2:0]  channelIn,
    output logic             rxData,
    output logic             modTx,         // modulator drive
    output logic             txEnable,
    output logic             rxEnable,
    output logic             busy,
    output logic [5:0]       powerLevel,
    output logic [1:0]       baudBand,
    output logic [2:0]       channel
);

    // present and next operating state
    rtmc_pkg::rtmc_state_t state_q;
    rtmc_pkg::rtmc_state_t state_d;

    // retune timer and the mode it is heading for
    logic [7:0]            swCnt_q;
    logic [7:0]            swCnt_d;
    logic                  target_q;     // mode being entered, high for transmit
    logic                  target_d;

    // switch state steering
    logic                  switchEntry;  // the switch state is entered at the next edge
    logic                  switchDone;   // timer spent and the target is still wanted
    logic                  retarget;     // select moved while the radio was retuning

    // power level capture bookkeeping
    logic                  levelTaken_q;
    logic                  levelTaken_d;
    logic [5:0]            level_d;
    logic [5:0]            strapClamped;

    // next values of the registered outputs
    logic                  busy_d;
    logic                  txEnable_d;
    logic                  rxEnable_d;
    logic                  modTx_d;
    logic                  rxData_d;

    // events that steer the switch state
    // a select change in mid retune must not end in the stale mode, so the
    // timer starts again toward the new target instead of finishing early
    always_comb
    begin
        switchDone = (swCnt_q == 8'h00) && (txSelect == target_q);
        retarget   = (state_q == rtmc_pkg::RTMC_SWITCH) && (txSelect != target_q);
    end

    // mode selection
    // power-down dominates standby, and standby dominates any mode change
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rtmc_pkg::RTMC_OFF:
            begin
                // waking up always passes through standby first
                state_d = rtmc_pkg::RTMC_STANDBY;
            end
            rtmc_pkg::RTMC_STANDBY:
            begin
                if (!standbyReq)
                    state_d = rtmc_pkg::RTMC_SWITCH;
            end
            rtmc_pkg::RTMC_SWITCH:
            begin
                if (switchDone)
                    state_d = target_q ? rtmc_pkg::RTMC_TX : rtmc_pkg::RTMC_RX;
            end
            rtmc_pkg::RTMC_RX:
            begin
                if (txSelect)
                    state_d = rtmc_pkg::RTMC_SWITCH;
            end
            rtmc_pkg::RTMC_TX:
            begin
                if (!txSelect)
                    state_d = rtmc_pkg::RTMC_SWITCH;
            end
            default:
            begin
                // an illegal code falls back to the safest state
                state_d = rtmc_pkg::RTMC_OFF;
            end
        endcase
        if (standbyReq && state_q != rtmc_pkg::RTMC_OFF)
            state_d = rtmc_pkg::RTMC_STANDBY;
        if (!powerDownN)
            state_d = rtmc_pkg::RTMC_OFF;
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_q <= rtmc_pkg::RTMC_OFF;
        else
            state_q <= state_d;
    end

    // retune timer next value
    // loaded at each entry to the switch state and at each retarget,
    // then counted down to zero while the radio settles
    always_comb
    begin
        switchEntry = (state_d == rtmc_pkg::RTMC_SWITCH) &&
                      (state_q != rtmc_pkg::RTMC_SWITCH);
        swCnt_d     = swCnt_q;
        target_d    = target_q;
        if (switchEntry || retarget)
        begin
            swCnt_d  = rtmc_pkg::SWITCH_LOAD - 8'h01;
            target_d = txSelect;
        end
        else if (state_q == rtmc_pkg::RTMC_SWITCH && swCnt_q != 8'h00)
        begin
            swCnt_d = swCnt_q - 8'h01;
        end
    end

    // retune timer register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            swCnt_q  <= 8'h00;
            target_q <= 1'b0;
        end
        else
        begin
            swCnt_q  <= swCnt_d;
            target_q <= target_d;
        end
    end

    // power level next value
    // the strap is only looked at in the first powered cycle; later moves
    // of the strap, standby or mode changes leave the level alone
    always_comb
    begin
        // clamp to the 58 valid steps, open strap reads as the top step
        strapClamped = (output_level_strap > rtmc_pkg::LEVEL_MAX) ?
                       rtmc_pkg::LEVEL_MAX : output_level_strap;
        levelTaken_d = levelTaken_q;
        level_d      = powerLevel;
        if (!powerDownN)
        begin
            // power-down ends the session, the next power-up measures again
            levelTaken_d = 1'b0;
        end
        else if (!levelTaken_q)
        begin
            levelTaken_d = 1'b1;
            level_d      = strapClamped;
        end
    end

    // power level register, six bits wide
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            powerLevel   <= rtmc_pkg::LEVEL_RST;
            levelTaken_q <= 1'b0;
        end
        else
        begin
            powerLevel   <= level_d;
            levelTaken_q <= levelTaken_d;
        end
    end

    // band and channel follow their inputs, mode changes never touch them
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            baudBand <= 2'h0;
            channel  <= 3'h0;
        end
        else
        begin
            baudBand <= baudBandIn;
            channel  <= channelIn;
        end
    end

    // busy flag: low when off, high in standby or switching
    // it is decoded from the next state so that it moves in the same
    // cycle as the mode enables and the host never sees a ready gap
    always_comb
    begin
        case (state_d)
            rtmc_pkg::RTMC_OFF:     busy_d = 1'b0;
            rtmc_pkg::RTMC_STANDBY: busy_d = 1'b1;
            rtmc_pkg::RTMC_SWITCH:  busy_d = 1'b1;
            default:                busy_d = 1'b0;
        endcase
    end

    // mode enables and data paths, next values
    // transmit copies the bare level with no framing, so any waveform at
    // any rate the radio can carry passes unchanged
    // receive copies the demodulator with no squelch, noise included
    always_comb
    begin
        txEnable_d = (state_d == rtmc_pkg::RTMC_TX);
        rxEnable_d = (state_d == rtmc_pkg::RTMC_RX);
        modTx_d    = txEnable_d & txData;
        rxData_d   = rxEnable_d & demodBit;
    end

    // ready/busy flag register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            busy <= 1'b0;
        else
            busy <= busy_d;
    end

    // transmit enable register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            txEnable <= 1'b0;
        else
            txEnable <= txEnable_d;
    end

    // receive enable register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rxEnable <= 1'b0;
        else
            rxEnable <= rxEnable_d;
    end

    // modulator drive register, idle low outside transmit
    always_ff @(posedge core_clk)
    begin
        if (rst)
            modTx <= 1'b0;
        else
            modTx <= modTx_d;
    end

    // receive data register, idle low outside receive
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rxData <= 1'b0;
        else
            rxData <= rxData_d;
    end

endmodule : rtmc_mode_ctrl

`default_nettype wire

// file: verif/rtmc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches the mode controller pins for timing relations between causes and outputs
module rtmc_props
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       powerDownN,
    input wire logic       standbyReq,
    input wire logic       txSelect,
    input wire logic       txData,
    input wire logic       demodBit,
    input wire logic       rxData,
    input wire logic       modTx,
    input wire logic       txEnable,
    input wire logic       rxEnable,
    input wire logic       busy,
    input wire logic [1:0] baudBandIn,
    input wire logic [1:0] baudBand,
    input wire logic [2:0] channelIn,
    input wire logic [2:0] channel,
    input wire logic [5:0] powerLevel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // data paths copy their input only in the matching mode
    a_tx_path: assert property (modTx == (txEnable & $past(txData)))
        else $error("tx path wrong");
    a_rx_path: assert property (rxData == (rxEnable & $past(demodBit)))
        else $error("rx path wrong");
    // select change starts a switch that keeps busy up
    a_sel_change: assert property ($changed(txSelect) && (txEnable || rxEnable)
        && powerDownN && !standbyReq |=> busy && !txEnable && !rxEnable) else $error("no switch");
    a_switch_hold: assert property ($rose(busy) |=> (busy || !$past(powerDownN))[*8])
        else $error("busy short");
    a_ready_mode: assert property ($fell(busy) && $past(powerDownN) |-> txEnable ^ rxEnable)
        else $error("ready without mode");
    a_stby_busy: assert property (powerDownN && standbyReq |=> busy && !txEnable && !rxEnable)
        else $error("standby wrong");
    a_off_quiet: assert property (!powerDownN
        |=> !(busy | txEnable | rxEnable | modTx | rxData))
        else $error("off not quiet");
    a_cfg_copy: assert property (!$past(rst) |-> baudBand == $past(baudBandIn)
        && channel == $past(channelIn)) else $error("settings lost");
    a_level_hold: assert property (!$past(rst, 2) && $past(powerDownN, 2)
        && $past(powerDownN) |-> $stable(powerLevel) && powerLevel <= 6'h39)
        else $error("level moved");
    c_tx_ready: cover property ($fell(busy) && txEnable);
    c_rx_ready: cover property ($fell(busy) && rxEnable);
    c_off: cover property ($fell(powerDownN));
endmodule : rtmc_props
bind rtmc_mode_ctrl rtmc_props i_rtmc_props (.*);
`default_nettype wire

// file: verif/rtmc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: streams a pattern, clears its lines before powering the module down
module rtmc_host
(
    input  wire logic core_clk,
    input  wire logic offReq,
    output logic      powerDownN = 1'b1,
    output logic      txData = 1'b0
);
    logic [3:0] pat_q = 4'h0;
    // data low first, power line low one cycle later
    always @(negedge core_clk)
    begin
        pat_q      <= pat_q + 4'h3;
        txData     <= ~offReq & pat_q[1];
        powerDownN <= ~(offReq & ~txData);
    end
endmodule : rtmc_host
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       core_clk = 1'b0, rst = 1'b1, offReq = 1'b0, standbyReq = 1'b1, txSelect = 1'b0;
    logic       demodBit = 1'b0, powerDownN, txData, rxData, modTx, txEnable, rxEnable, busy;
    logic [5:0] output_level_strap = 6'h3f, powerLevel;
    logic [1:0] baudBandIn = 2'h2, baudBand;
    logic [2:0] channelIn = 3'h5, channel;
    int         n_fail = 0, n_checks = 0, n;
    always #50 core_clk = ~core_clk;
    // unsquelched radio noise
    always @(negedge core_clk) demodBit <= ~demodBit;
    rtmc_host i_rtmc_host (.core_clk(core_clk), .offReq(offReq), .powerDownN(powerDownN),
        .txData(txData));
    rtmc_mode_ctrl i_rtmc_mode_ctrl
    (
        .core_clk           (core_clk),
        .rst                (rst),
        .powerDownN         (powerDownN),
        .standbyReq         (standbyReq),
        .txSelect           (txSelect),
        .txData             (txData),
        .demodBit           (demodBit),
        .output_level_strap (output_level_strap),
        .baudBandIn         (baudBandIn),
        .channelIn          (channelIn),
        .rxData             (rxData),
        .modTx              (modTx),
        .txEnable           (txEnable),
        .rxEnable           (rxEnable),
        .busy               (busy),
        .powerLevel         (powerLevel),
        .baudBand           (baudBand),
        .channel            (channel)
    );
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_idle;
        for (n = 0; busy !== 1'b0 && n < 40; n++) @(negedge core_clk);
        if (n >= 40)
        begin
            n_fail++;
            $display("ERROR busy expected 0 seen %b", busy);
        end
    endtask : wait_idle
    task automatic t_start;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("standby busy", 8'h01, {7'h0, busy});
        chk("level open", 8'h39, {2'h0, powerLevel});
        $display("test start done");
    endtask : t_start
    task automatic t_rx_tx;
        standbyReq = 1'b0;
        wait_idle;
        chk("rx mode", 8'h01, {7'h0, rxEnable});
        output_level_strap = 6'h00;
        txSelect = 1'b1;
        @(negedge core_clk);
        wait_idle;
        chk("switch len", 8'(rtmc_pkg::SWITCH_CYC), 8'(n));
        chk("tx mode", 8'h01, {7'h0, txEnable});
        chk("settings", 8'h15, {3'h0, baudBand, channel});
        chk("level kept", 8'h39, {2'h0, powerLevel});
        $display("test rx_tx done");
    endtask : t_rx_tx
    task automatic t_off;
        txSelect   = 1'b0;
        baudBandIn = 2'h0;
        channelIn  = 3'h0;
        @(negedge core_clk);
        offReq <= 1'b1;
        repeat (4) @(negedge core_clk);
        chk("off flags", 8'h00, {6'h0, busy, txEnable});
        offReq <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk("level ground", 8'h00, {2'h0, powerLevel});
        $display("test off done");
    endtask : t_off
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // watchdog cuts a hang
    initial
    begin
        #200000;
        n_fail++;
        wrap_up;
    end
    initial
    begin
        t_start;
        t_rx_tx;
        t_off;
        wrap_up;
    end
endmodule : tb_top
`default_nettype wire
